// file: core/exposure_timer.v
`timescale 1ns/1ps
`default_nettype none
module exposure_timer #(
  parameter W = 33
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         start,
  input  wire [W-1:0] target,
  input  wire [W-1:0] knee1Target,
  input  wire [W-1:0] knee2Target,
  input  wire         kneeEnable,
  output reg          done,
  output reg          knee1Hit,
  output reg          knee2Hit
);
  reg         active;
  reg [W-1:0] elapsed;

  // count clocks from start; pulse when each target is reached, the knee targets only while kneeEnable is set
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active   <= 1'b0;
      elapsed  <= {W{1'b0}};
      done     <= 1'b0;
      knee1Hit <= 1'b0;
      knee2Hit <= 1'b0;
    end else begin
      done     <= 1'b0;
      knee1Hit <= 1'b0;
      knee2Hit <= 1'b0;
      if (start) begin
        active  <= 1'b1;
        elapsed <= {{(W-1){1'b0}}, 1'b1};
      end else if (active) begin
        elapsed  <= elapsed + {{(W-1){1'b0}}, 1'b1};
        knee1Hit <= kneeEnable && (elapsed == knee1Target);
        knee2Hit <= kneeEnable && (elapsed == knee2Target);
        if (elapsed >= target) begin
          active <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: core/hdr_exposure_map.vh
`ifndef HDR_EXPOSURE_MAP_VH
`define HDR_EXPOSURE_MAP_VH
// =====================================================================
// register byte addresses
`define A_ROWS_LO   7'h01
`define A_ROWS_HI   7'h02
`define A_START_LO  7'h03
`define A_START_HI  7'h04
`define A_MODE      7'h29
`define A_EXP0      7'h2A
`define A_EXP1      7'h2B
`define A_EXP2      7'h2C
`define A_STEP0     7'h2D
`define A_STEP1     7'h2E
`define A_STEP2     7'h2F
`define A_KP1_0     7'h30
`define A_KP1_1     7'h31
`define A_KP1_2     7'h32
`define A_KP2_0     7'h33
`define A_KP2_1     7'h34
`define A_KP2_2     7'h35
`define A_SLOPES    7'h36
`define A_SEQ       7'h37
`define A_OVERHEAD  7'h49
`define A_CLIP2     7'h59
`define A_CLIP3     7'h5A
`define A_FRAMEIDX  7'h7E
`define A_STATUS    7'h7F
// =====================================================================
// reset values
`define R_ROWS      11'h440
`define R_START     11'h000
`define R_EXP       24'h000440
`define R_STEP      24'h000000
`define R_KP        24'h000001
`define R_SLOPES    2'h1
`define R_SEQ       8'h01
`define R_OVERHEAD  8'h0A
`define R_CLIP      7'h60
// =====================================================================
// field positions and timing
`define F_EXT       0
`define F_ALT       1
`define F_CLIP_EN   6
`define UNIT_CLKS   33'h000000081
`define OVH_NUM     33'h0000015AB
`define OVH_DEN     33'h000000064
`define ARRAY_ROWS  11'h440
`endif

// file: core/hdr_exposure_row_window_ctrl.v
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "hdr_exposure_map.vh"
module hdr_exposure_row_window_ctrl (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [6:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdData,
  input  wire        frameRequest,
  input  wire        exposurePulsePin,
  output reg         exposing,
  output reg         clipEnable,
  output reg  [5:0]  clipDacCode,
  output reg  [1:0]  slopePhase,
  output reg         altRowExposure,
  output reg         frameStart,
  output wire        frameEnd,
  output wire [10:0] rowAddr,
  output wire        rowValid,
  output reg  [7:0]  frameIndex,
  output wire        busy
);
  // =====================================================================
  // states
  localparam [3:0] S_IDLE   = 4'b0001;
  localparam [3:0] S_EXTEXP = 4'b0010;
  localparam [3:0] S_EXPOSE = 4'b0100;
  localparam [3:0] S_READ   = 4'b1000;

  // =====================================================================
  // configuration registers
  reg [10:0] readoutRowTotal;
  reg [10:0] windowFirstRow;
  reg        externalExposureSelect;
  reg        alternateRowExposureEnable;
  reg [23:0] exposureLength;
  reg [23:0] exposureIncrementStep;
  reg [23:0] knee1Exposure;
  reg [23:0] knee2Exposure;
  reg [1:0]  slopeCount;
  reg [7:0]  frameSequenceCount;
  reg [7:0]  transferOverheadLength;
  reg [6:0]  clipLevelSecond;
  reg [6:0]  clipLevelThird;

  reg [3:0]  state;
  reg [23:0] curUnits;
  reg        timerStart;
  reg        scanStart;
  reg        extMode;
  reg [32:0] expTarget;
  wire       timerDone;
  wire       knee1Hit;
  wire       knee2Hit;
  wire       scanDone;

  // overhead cycles: 129 * 0.43 * overhead, rounded up to whole clocks
  function [32:0] overheadClks;
    input [7:0] ovh;
    begin
      overheadClks = ({25'h0, ovh} * `OVH_NUM + `OVH_DEN - 33'h1) / `OVH_DEN;
    end
  endfunction

  // clocks for a register count: overhead plus 129 clocks per unit
  function [32:0] unitClks;
    input [23:0] units;
    input [7:0]  ovh;
    begin
      unitClks = overheadClks(ovh) + {9'h0, units} * `UNIT_CLKS;
    end
  endfunction

  // =====================================================================
  // register writes, least significant byte at the lowest address
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readoutRowTotal            <= `R_ROWS;
      windowFirstRow             <= `R_START;
      externalExposureSelect     <= 1'b0;
      alternateRowExposureEnable <= 1'b0;
      exposureLength             <= `R_EXP;
      exposureIncrementStep      <= `R_STEP;
      knee1Exposure              <= `R_KP;
      knee2Exposure              <= `R_KP;
      slopeCount                 <= `R_SLOPES;
      frameSequenceCount         <= `R_SEQ;
      transferOverheadLength     <= `R_OVERHEAD;
      clipLevelSecond            <= `R_CLIP;
      clipLevelThird             <= `R_CLIP;
    end else if (regWrite) begin
      case (regAddr)
        `A_ROWS_LO:  readoutRowTotal[7:0]        <= regWrData;
        `A_ROWS_HI:  readoutRowTotal[10:8]       <= regWrData[2:0];
        `A_START_LO: windowFirstRow[7:0]         <= regWrData;
        `A_START_HI: windowFirstRow[10:8]        <= regWrData[2:0];
        `A_MODE: begin
          externalExposureSelect     <= regWrData[`F_EXT];
          alternateRowExposureEnable <= regWrData[`F_ALT];
        end
        `A_EXP0:     exposureLength[7:0]         <= regWrData;
        `A_EXP1:     exposureLength[15:8]        <= regWrData;
        `A_EXP2:     exposureLength[23:16]       <= regWrData;
        `A_STEP0:    exposureIncrementStep[7:0]  <= regWrData;
        `A_STEP1:    exposureIncrementStep[15:8] <= regWrData;
        `A_STEP2:    exposureIncrementStep[23:16] <= regWrData;
        `A_KP1_0:    knee1Exposure[7:0]          <= regWrData;
        `A_KP1_1:    knee1Exposure[15:8]         <= regWrData;
        `A_KP1_2:    knee1Exposure[23:16]        <= regWrData;
        `A_KP2_0:    knee2Exposure[7:0]          <= regWrData;
        `A_KP2_1:    knee2Exposure[15:8]         <= regWrData;
        `A_KP2_2:    knee2Exposure[23:16]        <= regWrData;
        `A_SLOPES:   slopeCount                  <= regWrData[1:0];
        `A_SEQ:      frameSequenceCount          <= regWrData;
        `A_OVERHEAD: transferOverheadLength      <= regWrData;
        `A_CLIP2:    clipLevelSecond             <= regWrData[6:0];
        `A_CLIP3:    clipLevelThird              <= regWrData[6:0];
        default: ;
      endcase
    end
  end

  // =====================================================================
  // register reads, answered in the next cycle; unmapped reads give zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `A_ROWS_LO:  regRdData <= readoutRowTotal[7:0];
        `A_ROWS_HI:  regRdData <= {5'h00, readoutRowTotal[10:8]};
        `A_START_LO: regRdData <= windowFirstRow[7:0];
        `A_START_HI: regRdData <= {5'h00, windowFirstRow[10:8]};
        `A_MODE:     regRdData <= {6'h00, alternateRowExposureEnable, externalExposureSelect};
        `A_EXP0:     regRdData <= exposureLength[7:0];
        `A_EXP1:     regRdData <= exposureLength[15:8];
        `A_EXP2:     regRdData <= exposureLength[23:16];
        `A_STEP0:    regRdData <= exposureIncrementStep[7:0];
        `A_STEP1:    regRdData <= exposureIncrementStep[15:8];
        `A_STEP2:    regRdData <= exposureIncrementStep[23:16];
        `A_KP1_0:    regRdData <= knee1Exposure[7:0];
        `A_KP1_1:    regRdData <= knee1Exposure[15:8];
        `A_KP1_2:    regRdData <= knee1Exposure[23:16];
        `A_KP2_0:    regRdData <= knee2Exposure[7:0];
        `A_KP2_1:    regRdData <= knee2Exposure[15:8];
        `A_KP2_2:    regRdData <= knee2Exposure[23:16];
        `A_SLOPES:   regRdData <= {6'h00, slopeCount};
        `A_SEQ:      regRdData <= frameSequenceCount;
        `A_OVERHEAD: regRdData <= transferOverheadLength;
        `A_CLIP2:    regRdData <= {1'b0, clipLevelSecond};
        `A_CLIP3:    regRdData <= {1'b0, clipLevelThird};
        `A_FRAMEIDX: regRdData <= frameIndex;
        `A_STATUS:   regRdData <= {3'h0, exposing, state};
        default:     regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // =====================================================================
  // exposure target for the timer: full time inside, overhead only after pins
  always @* begin
    if (extMode) begin
      expTarget = overheadClks(transferOverheadLength);
    end else begin
      expTarget = unitClks(curUnits, transferOverheadLength);
    end
  end

  exposure_timer #(
    .W (33)
  ) u_timer (
    .clk         (clk),
    .rst_n       (rst_n),
    .start       (timerStart),
    .target      (expTarget),
    .knee1Target (unitClks(knee1Exposure, transferOverheadLength)),
    .knee2Target (unitClks(knee2Exposure, transferOverheadLength)),
    .kneeEnable  (!extMode),
    .done        (timerDone),
    .knee1Hit    (knee1Hit),
    .knee2Hit    (knee2Hit)
  );

  // single window scan; subwindows would reuse the same scan per window
  row_window_scan #(
    .RW (11)
  ) u_scan (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (scanStart),
    .firstRow  (windowFirstRow),
    .arrayRows (`ARRAY_ROWS),
    .rowTotal  (readoutRowTotal),
    .rowAddr   (rowAddr),
    .rowValid  (rowValid),
    .done      (scanDone)
  );

  assign frameEnd = scanDone;
  assign busy     = (state != S_IDLE);

  // =====================================================================
  // frame sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= S_IDLE;
      curUnits       <= `R_EXP;
      timerStart     <= 1'b0;
      scanStart      <= 1'b0;
      extMode        <= 1'b0;
      exposing       <= 1'b0;
      frameStart     <= 1'b0;
      frameIndex     <= 8'h00;
      altRowExposure <= 1'b0;
    end else begin
      timerStart     <= 1'b0;
      scanStart      <= 1'b0;
      frameStart     <= 1'b0;
      altRowExposure <= alternateRowExposureEnable;
      case (state)
        S_IDLE: begin
          frameIndex <= 8'h00;
          if (externalExposureSelect && exposurePulsePin) begin
            extMode  <= 1'b1;
            exposing <= 1'b1;
            state    <= S_EXTEXP;
          end else if (!externalExposureSelect && frameRequest) begin
            extMode    <= 1'b0;
            curUnits   <= exposureLength;
            exposing   <= 1'b1;
            timerStart <= 1'b1;
            state      <= S_EXPOSE;
          end
        end
        S_EXTEXP: begin
          // pin time runs until the frame request, then overhead follows
          if (frameRequest) begin
            timerStart <= 1'b1;
            state      <= S_EXPOSE;
          end
        end
        S_EXPOSE: begin
          if (timerDone) begin
            exposing   <= 1'b0;
            scanStart  <= 1'b1;
            frameStart <= 1'b1;
            frameIndex <= frameIndex + 8'h01;
            state      <= S_READ;
          end
        end
        S_READ: begin
          if (scanDone) begin
            if (!extMode && (frameIndex < frameSequenceCount)) begin
              curUnits   <= curUnits + exposureIncrementStep;
              exposing   <= 1'b1;
              timerStart <= 1'b1;
              state      <= S_EXPOSE;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // =====================================================================
  // clip level sequencing through the slopes of one exposure
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slopePhase  <= 2'h0;
      clipEnable  <= 1'b0;
      clipDacCode <= 6'h00;
    end else if (!exposing) begin
      slopePhase  <= 2'h0;
      clipEnable  <= 1'b0;
      clipDacCode <= 6'h00;
    end else if ((slopePhase == 2'h0) && (slopeCount > 2'h1) &&
                 (knee1Hit || (extMode && state == S_EXTEXP && exposurePulsePin))) begin
      slopePhase  <= 2'h1;
      clipEnable  <= clipLevelSecond[`F_CLIP_EN];
      clipDacCode <= clipLevelSecond[5:0];
    end else if ((slopePhase == 2'h1) && (slopeCount > 2'h2) &&
                 (knee2Hit || (extMode && state == S_EXTEXP && exposurePulsePin))) begin
      slopePhase  <= 2'h2;
      clipEnable  <= clipLevelThird[`F_CLIP_EN];
      clipDacCode <= clipLevelThird[5:0];
    end
  end
endmodule
`default_nettype wire

// file: core/row_window_scan.v
`timescale 1ns/1ps
`default_nettype none
module row_window_scan #(
  parameter RW = 11
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          start,
  input  wire [RW-1:0] firstRow,
  input  wire [RW-1:0] arrayRows,
  input  wire [RW-1:0] rowTotal,
  output reg  [RW-1:0] rowAddr,
  output reg           rowValid,
  output reg           done
);
  reg [RW-1:0] left;

  // one row per clock from the first row, wrapping at the array edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rowAddr  <= {RW{1'b0}};
      rowValid <= 1'b0;
      left     <= {RW{1'b0}};
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rowAddr  <= firstRow;
        rowValid <= 1'b1;
        left     <= rowTotal - {{(RW-1){1'b0}}, 1'b1};
      end else if (rowValid) begin
        if (left == {RW{1'b0}}) begin
          rowValid <= 1'b0;
          done     <= 1'b1;
        end else begin
          left    <= left - {{(RW-1){1'b0}}, 1'b1};
          rowAddr <= (rowAddr + {{(RW-1){1'b0}}, 1'b1} >= arrayRows) ? {RW{1'b0}}
                     : rowAddr + {{(RW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/capture_partner.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// capture controller: requests frames, measures what arrives
module capture_partner (
  input  wire logic        clk,
  input  wire logic        exposing,
  input  wire logic [1:0]  slopePhase,
  input  wire logic        clipEnable,
  input  wire logic [5:0]  clipDacCode,
  input  wire logic        frameEnd,
  input  wire logic [10:0] rowAddr,
  input  wire logic        rowValid,
  output var  logic        frameRequest,
  output var  logic        exposurePulsePin
);
  int          expCnt, k1At, k2At, rows, frames, nLen;
  int          lens[8];
  logic [6:0]  clip2, clip3;
  logic [10:0] firstRow;
  logic        prevExp;
  task automatic clear();
    k1At = 0; k2At = 0; rows = 0; frames = 0; nLen = 0;
    clip2 = 'x; clip3 = 'x;
  endtask
  // pulses held over exactly one sampling edge
  task automatic request();
    @(posedge clk) frameRequest <= 1'b1;
    @(posedge clk) frameRequest <= 1'b0;
  endtask
  task automatic pin();
    @(posedge clk) exposurePulsePin <= 1'b1;
    @(posedge clk) exposurePulsePin <= 1'b0;
  endtask
  initial begin
    frameRequest = 1'b0;
    exposurePulsePin = 1'b0;
    prevExp = 1'b0;
    clear();
  end
  // frames are kept apart, never merged
  always @(negedge clk) begin
    if (exposing) begin
      expCnt = prevExp ? expCnt + 1 : 1;
      if (slopePhase == 2'h1 && k1At == 0) begin
        k1At = expCnt;
        clip2 = {clipEnable, clipDacCode};
      end
      if (slopePhase == 2'h2 && k2At == 0) begin
        k2At = expCnt;
        clip3 = {clipEnable, clipDacCode};
      end
    end else if (prevExp) begin
      lens[nLen % 8] = expCnt;
      nLen++;
    end
    prevExp = exposing;
    if (rowValid) begin
      if (rows == 0) firstRow = rowAddr;
      rows++;
    end
    if (frameEnd) frames++;
  end
endmodule
`default_nettype wire

// file: verification/hdr_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// port checks
module hdr_ctrl_props (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        regRead,
  input wire logic [7:0]  regRdData,
  input wire logic        exposing,
  input wire logic [5:0]  clipDacCode,
  input wire logic [1:0]  slopePhase,
  input wire logic        frameStart,
  input wire logic        frameEnd,
  input wire logic [10:0] rowAddr,
  input wire logic        rowValid,
  input wire logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data not idle");
  a_fs_pulse: assert property (frameStart |=> !frameStart)
    else $error("frame start too long");
  a_rows_follow: assert property (frameStart |=> rowValid)
    else $error("rows late after frame start");
  a_end_rows: assert property ($fell(rowValid) |-> frameEnd)
    else $error("frame end missing");
  a_end_pulse: assert property (frameEnd |=> !frameEnd)
    else $error("frame end too long");
  a_expose_fs: assert property ($fell(exposing) |-> frameStart)
    else $error("read-out not at exposure end");
  a_busy_exp: assert property (exposing |-> busy)
    else $error("exposing while idle");
  a_clip_first: assert property (exposing && slopePhase == 2'h0 |-> clipDacCode == 6'h00)
    else $error("clip code in first slope");
  a_phase_step: assert property (exposing && $past(exposing) && slopePhase != $past(slopePhase)
    |-> slopePhase == $past(slopePhase) + 2'h1)
    else $error("slope phase skipped");
  a_row_step: assert property (rowValid && $past(rowValid)
    |-> rowAddr == (($past(rowAddr) == 11'h43F) ? 11'h000 : $past(rowAddr) + 11'h001))
    else $error("row address not consecutive");
endmodule
`default_nettype wire

// file: verification/hdr_exposure_row_window_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hdr_exposure_row_window_ctrl_tb;
  logic        clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [6:0]  regAddr = 7'h00;
  logic [7:0]  regWrData = 8'h00;
  wire  [7:0]  regRdData, frameIndex;
  wire  [5:0]  clipDacCode;
  wire  [1:0]  slopePhase;
  wire  [10:0] rowAddr;
  wire         frameRequest, exposurePulsePin, exposing, clipEnable, altRowExposure;
  wire         frameStart, frameEnd, rowValid, busy;
  int          fail_count = 0, n_tests = 0;
  int          i, s, ov, st, nr, seq, inc, fi;
  logic [7:0]  d, c2, c3;
  logic [6:0]  ra[17] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h30, 7'h33,
                         7'h36, 7'h37, 7'h59, 7'h5A, 7'h10, 7'h7E, 7'h7F};
  logic [7:0]  rv[17] = '{8'h40, 8'h04, 8'h00, 8'h00, 8'h40, 8'h04, 8'h00, 8'h00, 8'h01, 8'h01,
                         8'h01, 8'h01, 8'h60, 8'h60, 8'h00, 8'h00, 8'h01};
  logic [6:0]  wa[5] = '{7'h36, 7'h59, 7'h5A, 7'h02, 7'h37};
  logic [7:0]  wm[5] = '{8'h03, 8'h7F, 8'h7F, 8'h07, 8'hFF};
  always #10 clk = ~clk;
  hdr_exposure_row_window_ctrl hdr_exposure_row_window_ctrl_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .frameRequest(frameRequest), .exposurePulsePin(exposurePulsePin), .exposing(exposing),
    .clipEnable(clipEnable), .clipDacCode(clipDacCode), .slopePhase(slopePhase),
    .altRowExposure(altRowExposure), .frameStart(frameStart), .frameEnd(frameEnd), .rowAddr(rowAddr),
    .rowValid(rowValid), .frameIndex(frameIndex), .busy(busy));
  capture_partner capture_partner_i (.clk(clk), .exposing(exposing), .slopePhase(slopePhase),
    .clipEnable(clipEnable), .clipDacCode(clipDacCode), .frameEnd(frameEnd), .rowAddr(rowAddr),
    .rowValid(rowValid), .frameRequest(frameRequest), .exposurePulsePin(exposurePulsePin));
  // =====
  // bench tasks
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [6:0] a, logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk("register", v, regRdData);
  endtask
  task automatic wr24(logic [6:0] a, logic [23:0] v);
    wr(a, v[7:0]);
    wr(a + 7'h01, v[15:8]);
    wr(a + 7'h02, v[23:16]);
  endtask
  task automatic run();
    capture_partner_i.clear();
    capture_partner_i.request();
    i = 0;
    fi = 0;
    do begin
      @(negedge clk);
      if (frameIndex > fi) fi = frameIndex;
      i++;
    end while (busy !== 1'b0 && i < 6000);
    if (i >= 6000) begin
      chk("idle timeout", 0, 1);
      end_sim();
    end
  endtask
  // exposing lasts the formula time plus two cycles of start and end latency
  function automatic int expLen(int o, int u);
    return (o * 5547 + 99) / 100 + 129 * u + 2;
  endfunction
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #(20 * 40000);
    fail_count++;
    end_sim();
  end
  // =====
  // main sequence
  initial begin
    void'($urandom(39));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 17; k++) rd(ra[k], rv[k]);
    for (int k = 0; k < 5; k++) begin
      d = 8'($urandom);
      wr(wa[k], d);
      rd(wa[k], d & wm[k]);
    end
    // full array at reset geometry, shortest exposure
    wr(7'h02, 8'h04);
    wr(7'h49, 8'h00);
    wr24(7'h2A, 24'h000001);
    wr(7'h37, 8'h01);
    wr(7'h36, 8'h01);
    run();
    chk("rows", 1088, capture_partner_i.rows);
    chk("first row", 0, capture_partner_i.firstRow);
    chk("exposure", expLen(0, 1), capture_partner_i.lens[0]);
    // random overhead and window
    ov = $urandom_range(1, 3);
    st = $urandom_range(0, 1087);
    nr = $urandom_range(1, 8);
    wr(7'h49, ov[7:0]);
    wr(7'h03, st[7:0]);
    wr(7'h04, st[15:8]);
    wr(7'h01, nr[7:0]);
    wr(7'h02, 8'h00);
    run();
    chk("exposure", expLen(ov, 1), capture_partner_i.lens[0]);
    chk("rows", nr, capture_partner_i.rows);
    chk("first row", st, capture_partner_i.firstRow);
    // multi-frame with stepped exposure
    wr(7'h49, 8'h00);
    seq = $urandom_range(2, 4);
    inc = $urandom_range(0, 3);
    wr24(7'h2D, inc[23:0]);
    wr(7'h37, seq[7:0]);
    run();
    for (int n = 0; n < seq; n++) chk("frame exposure", expLen(0, 1 + n * inc), capture_partner_i.lens[n]);
    chk("frames", seq, capture_partner_i.frames);
    chk("frame index", seq, fi);
    chk("rows", seq * nr, capture_partner_i.rows);
    // kneepoints for slope counts one to three
    wr(7'h37, 8'h01);
    wr24(7'h2A, 24'h000004);
    wr24(7'h30, 24'h000001);
    wr24(7'h33, 24'h000002);
    c2 = 8'($urandom_range(0, 127));
    c3 = 8'($urandom_range(0, 127));
    wr(7'h59, c2);
    wr(7'h5A, c3);
    for (s = 1; s < 4; s++) begin
      wr(7'h36, s[7:0]);
      run();
      chk("knee one", (s >= 2) ? 132 : 0, capture_partner_i.k1At);
      chk("knee two", (s == 3) ? 261 : 0, capture_partner_i.k2At);
      chk("exposure", expLen(0, 4), capture_partner_i.lens[0]);
    end
    chk("second clip", c2[6:0], capture_partner_i.clip2);
    chk("third clip", c3[6:0], capture_partner_i.clip3);
    // alternate rows only with a linear response; altRowExposure follows the mode bit alone, whatever the slope count
    wr(7'h36, 8'h01);
    wr(7'h29, 8'h02);
    repeat (2) @(negedge clk);
    chk("alt rows", 1, altRowExposure);
    wr(7'h29, 8'h01);
    repeat (2) @(negedge clk);
    chk("alt rows", 0, altRowExposure);
    // external exposure, two knee pulses, wrapping window
    wr(7'h36, 8'h03);
    wr(7'h03, 8'h3F);
    wr(7'h04, 8'h04);
    wr(7'h01, 8'h03);
    capture_partner_i.clear();
    capture_partner_i.pin();
    capture_partner_i.pin();
    capture_partner_i.pin();
    @(negedge clk);
    chk("ext phase", 2, slopePhase);
    chk("ext third clip", c3[6:0], {clipEnable, clipDacCode});
    run();
    // pin-to-request span, at least one overhead clock, two cycles of latency
    chk("ext exposure", 9, capture_partner_i.lens[0]);
    chk("ext frames", 1, capture_partner_i.frames);
    chk("ext first row", 1087, capture_partner_i.firstRow);
    end_sim();
  end
endmodule
bind hdr_exposure_row_window_ctrl hdr_ctrl_props props_i (.clk(clk), .rst_n(rst_n), .regRead(regRead),
  .regRdData(regRdData), .exposing(exposing), .clipDacCode(clipDacCode), .slopePhase(slopePhase),
  .frameStart(frameStart), .frameEnd(frameEnd), .rowAddr(rowAddr), .rowValid(rowValid), .busy(busy));
`default_nettype wire
